/* core/idle_slow_ctrl.sv */
`timescale 1ns/100ps
// Notes on behaviour
// RL1 - leave tbt halt on selected clock fall
// RL2 - normal release resumes at next instruction
// RL3 - tbt_enable set: latch tbt interrupt
// RL4 - interrupt release starts tbt interrupt service
// RL5 - release timed by asynchronous tbt clock
// RL6 - watchdog interrupt before entry blocks halt
// RL7 - slow select switches to low clock/4
// RL8 - stall main clock during fs/4 alignment on the switch to slow
// RL9 - software waits two cycles before high-osc stop
// RL10 - early oscillator stop raises system clock reset
// RL11 - software stops high oscillator before STOP
// RL12 - software checks low clock stable first
// RL13 - software enables, waits stable, clears slow
// RL14 - clearing slow select returns to gear clock
// RL15 - return stall at most 2.5 gear cycles
// RL16 - software waits two cycles before low-osc stop
// RL17 - reset ends slow, warm-up, then single run
// RL18 - high-osc enable with port off: clock reset
// RL19 - rewriting set high-osc enable: no warm-up
// RL20 - slow select bit 4, high-osc bit 6
// RL21 - release clears halt bit, restores mode
// RL22 - mode register updates on switch completion
module idle_slow_ctrl
  import clk_mode_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // pins and neighbours
  input  wire logic        lowClkPin,
  input  wire logic [3:0]  tbtSrcPin,
  input  wire logic        extResetPin,
  input  wire logic        highOscStable,
  input  wire logic        lowOscStable,
  input  wire logic        wdtIrq,
  input  wire logic        tbtAck,
  output logic             highOscEn,
  output logic             lowOscEn,
  output logic             warmupStart,
  output logic             sysClkReset,
  output logic             mainClkSlow,
  output logic             mainClkStall,
  output logic             haltActive,
  output logic             haltSlow,
  output logic             resumeNext,
  output logic             tbtService,
  output logic             wdtService,
  output logic             tbtIrqLatch
);

  logic [5:0] pinLevel;
  logic [5:0] pinRise;
  logic [5:0] pinFall;
  logic       extReset;
  logic       tbtFall;

  logic       slowSel_q;
  logic       lowOsc_q;
  logic       highOsc_q;
  logic       halt_q;
  logic       haltSlow_q;
  logic [2:0] tbtSel_q;
  logic       tbt_enable_q;
  logic       ime_q;
  logic       tbtIe_q;
  logic       p0Osc_q;
  logic       latch_q;
  logic       scrFlag_q;
  logic [2:0] guard_q;
  logic       warmup_q;
  logic       resume_q;
  logic       service_q;
  logic       wdtSvc_q;
  logic       scr_q;
  logic [31:0] rdata_q;
  logic       err_q;
  run_mode_t  mode_q;

  logic       setupPh;
  logic       wrAcc;
  logic       wrSys;
  logic       wrTbt;
  logic       wrCpu;
  logic       wrSt;
  logic       haltEnter;
  logic       haltRel;
  logic       earlyStop;
  logic       badOsc;

  clk_switch_if swIf ();

  // ==========================================================
  // pin synchronisers
  pin_sync_edge u_sync (
    .clk   (clk),
    .srst  (srst),
    .pinIn ({extResetPin, tbtSrcPin, lowClkPin}),
    .level (pinLevel),
    .rise  (pinRise),
    .fall  (pinFall)
  );

  assign extReset = pinLevel[5];
  // RL1 RL5
  assign tbtFall  = pinFall[1 + 32'(tbtSel_q[1:0])];

  // ==========================================================
  // main clock switch
  main_clk_switch u_switch (
    .clk  (clk),
    .srst (srst),
    .sw   (swIf.sw)
  );

  assign swIf.toSlow = slowSel_q;
  assign swIf.fsRise = pinRise[0];

  // ==========================================================
  // apb decode
  function automatic logic isMapped(input logic [11:0] a);
    isMapped = (a == SYS_CTRL_OFS) || (a == TBT_CTRL_OFS) ||
               (a == CPU_CTRL_OFS) || (a == STATUS_OFS);
  endfunction

  assign setupPh = psel && !penable;
  assign wrAcc   = psel && penable && pwrite && isMapped(paddr);
  assign wrSys   = wrAcc && (paddr == SYS_CTRL_OFS);
  assign wrTbt   = wrAcc && (paddr == TBT_CTRL_OFS);
  assign wrCpu   = wrAcc && (paddr == CPU_CTRL_OFS);
  assign wrSt    = wrAcc && (paddr == STATUS_OFS);
  assign pready  = 1'b1;
  assign prdata  = rdata_q;
  assign pslverr = err_q;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end
    else if (setupPh)
    begin
      err_q <= !isMapped(paddr);
      case (paddr)
        SYS_CTRL_OFS:
          rdata_q <= 32'({highOsc_q, lowOsc_q, slowSel_q, 1'b0,
                          halt_q, 2'b00}); // RL20
        TBT_CTRL_OFS:
          rdata_q <= 32'({tbt_enable_q, tbtSel_q});
        CPU_CTRL_OFS:
          rdata_q <= 32'({p0Osc_q, tbtIe_q, ime_q});
        STATUS_OFS:
          rdata_q <= 32'({scrFlag_q, swIf.selSlow, swIf.busy,
                          latch_q, halt_q, mode_q});
        default:
          rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // halt entry and release
  assign haltEnter = wrSys && pwdata[TG_HALT_BIT] && !halt_q;
  assign haltRel   = halt_q && tbtFall; // RL1

  always_ff @(posedge clk)
  begin
    if (srst || extReset)
    begin
      halt_q     <= 1'b0;
      haltSlow_q <= 1'b0;
      wdtSvc_q   <= 1'b0;
    end
    else
    begin
      wdtSvc_q <= 1'b0;
      if (haltRel)
        halt_q <= 1'b0; // RL21
      else if (haltEnter)
      begin
        if (wdtIrq)
          wdtSvc_q <= 1'b1; // RL6
        else
        begin
          halt_q     <= 1'b1;
          haltSlow_q <= (mode_q == MODE_LOW);
        end
      end
    end
  end

  // release forms
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      resume_q  <= 1'b0;
      service_q <= 1'b0;
    end
    else
    begin
      resume_q <= haltRel && !(ime_q && tbtIe_q && tbt_enable_q); // RL2
      if (haltRel && ime_q && tbtIe_q && tbt_enable_q)
        service_q <= 1'b1; // RL4
      else if (tbtAck)
        service_q <= 1'b0;
    end
  end

  // tbt interrupt latch: set wins over clear
  always_ff @(posedge clk)
  begin
    if (srst)
      latch_q <= 1'b0;
    else if (haltRel && tbt_enable_q)
      latch_q <= 1'b1; // RL3
    else if (wrSt && pwdata[ST_LATCH_BIT])
      latch_q <= 1'b0;
  end

  // ==========================================================
  // control registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      tbtSel_q <= TBT_CTRL_RST[2:0];
      tbt_enable_q  <= TBT_CTRL_RST[TBT_EN_BIT];
      ime_q    <= CPU_CTRL_RST[IME_BIT];
      tbtIe_q  <= CPU_CTRL_RST[TBT_IE_BIT];
      p0Osc_q  <= CPU_CTRL_RST[P0_OSC_BIT];
    end
    else
    begin
      if (wrTbt)
      begin
        tbtSel_q <= pwdata[TBT_SEL_LSB +: 3];
        tbt_enable_q  <= pwdata[TBT_EN_BIT];
      end
      if (wrCpu)
      begin
        ime_q   <= pwdata[IME_BIT];
        tbtIe_q <= pwdata[TBT_IE_BIT];
        p0Osc_q <= pwdata[P0_OSC_BIT];
      end
    end
  end

  // oscillator enables and slow select
  always_ff @(posedge clk)
  begin
    if (srst || extReset)
    begin
      slowSel_q <= SYS_CTRL_RST[SLOW_SEL_BIT]; // RL17
      lowOsc_q  <= SYS_CTRL_RST[LOW_OSC_BIT];
      highOsc_q <= SYS_CTRL_RST[HIGH_OSC_BIT];
    end
    else if (wrSys)
    begin
      slowSel_q <= pwdata[SLOW_SEL_BIT]; // RL20
      lowOsc_q  <= pwdata[LOW_OSC_BIT];
      highOsc_q <= pwdata[HIGH_OSC_BIT];
    end
  end

  // ==========================================================
  // system clock reset guard
  assign earlyStop = wrSys && (guard_q != 3'h0) &&
                     ((slowSel_q && highOsc_q &&
                       !pwdata[HIGH_OSC_BIT]) ||
                      (!slowSel_q && lowOsc_q &&
                       !pwdata[LOW_OSC_BIT])); // RL10
  assign badOsc    = wrSys && pwdata[HIGH_OSC_BIT] &&
                     !p0Osc_q; // RL18

  always_ff @(posedge clk)
  begin
    if (srst)
      guard_q <= 3'h0;
    else if (wrSys && (pwdata[SLOW_SEL_BIT] != slowSel_q))
      guard_q <= 3'(GUARD_CYC); // RL10
    else if (guard_q != 3'h0)
      guard_q <= guard_q - 3'h1;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      scr_q     <= 1'b0;
      scrFlag_q <= 1'b0;
    end
    else
    begin
      scr_q <= earlyStop || badOsc;
      if (earlyStop || badOsc)
        scrFlag_q <= 1'b1;
      else if (wrSt && pwdata[ST_SCR_BIT])
        scrFlag_q <= 1'b0;
    end
  end

  // ==========================================================
  // warm-up start on rising enable with port on (p0Osc_q set), and on external reset outside warm-up
  always_ff @(posedge clk)
  begin
    if (srst)
      warmup_q <= 1'b0;
    else
      warmup_q <= (wrSys && pwdata[HIGH_OSC_BIT] && !highOsc_q &&
                   p0Osc_q) || // RL19
                  (extReset && mode_q != MODE_WARMUP);
  end

  // ==========================================================
  // operating mode
  always_ff @(posedge clk)
  begin
    if (srst || extReset)
      mode_q <= MODE_WARMUP; // RL17
    else
    begin
      case (mode_q)
        MODE_WARMUP:
          if (highOscStable)
            mode_q <= MODE_SINGLE; // RL17
        MODE_SINGLE:
          if (lowOsc_q && lowOscStable)
            mode_q <= MODE_DUAL;
        MODE_DUAL:
          if (swIf.done && !swIf.selSlow)
            mode_q <= MODE_LOW; // RL22
          else if (!lowOsc_q && !swIf.busy)
            mode_q <= MODE_SINGLE;
        MODE_LOW:
          if (swIf.done)
            mode_q <= MODE_DUAL; // RL22
        default:
          mode_q <= MODE_WARMUP;
      endcase
    end
  end

  // ==========================================================
  // outputs
  assign highOscEn    = highOsc_q;
  assign lowOscEn     = lowOsc_q;
  assign warmupStart  = warmup_q;
  assign sysClkReset  = scr_q;
  assign mainClkSlow  = swIf.selSlow;
  assign mainClkStall = swIf.stall;
  assign haltActive   = halt_q;
  assign haltSlow     = haltSlow_q;
  assign resumeNext   = resume_q;
  assign tbtService   = service_q;
  assign wdtService   = wdtSvc_q;
  assign tbtIrqLatch  = latch_q;

endmodule

/* core/clk_mode_pkg.sv */
package clk_mode_pkg;

  // ==========================================================
  // register map
  localparam logic [11:0] SYS_CTRL_OFS  = 12'h000;
  localparam logic [11:0] TBT_CTRL_OFS  = 12'h004;
  localparam logic [11:0] CPU_CTRL_OFS  = 12'h008;
  localparam logic [11:0] STATUS_OFS    = 12'h00C;

  // sys_control_two fields
  localparam int TG_HALT_BIT    = 2;
  localparam int SLOW_SEL_BIT   = 4;
  localparam int LOW_OSC_BIT    = 5;
  localparam int HIGH_OSC_BIT   = 6;
  // tbt_control_reg fields
  localparam int TBT_SEL_LSB    = 0;
  localparam int TBT_EN_BIT     = 3;
  // cpu control fields
  localparam int IME_BIT        = 0;
  localparam int TBT_IE_BIT     = 1;
  localparam int P0_OSC_BIT     = 2;
  // status fields
  localparam int ST_MODE_LSB    = 0;
  localparam int ST_HALT_BIT    = 4;
  localparam int ST_LATCH_BIT   = 5;
  localparam int ST_BUSY_BIT    = 6;
  localparam int ST_SEL_BIT     = 7;
  localparam int ST_SCR_BIT     = 8;

  // reset values
  localparam logic [7:0] SYS_CTRL_RST = 8'h40;
  localparam logic [3:0] TBT_CTRL_RST = 4'h0;
  localparam logic [2:0] CPU_CTRL_RST = 3'h0;

  // ==========================================================
  // timing, clk at 20 MHz, gear clock taken equal to clk
  localparam int CLK_NS         = 50;
  localparam int GEAR_NS        = 50;
  localparam int MACH_NS        = 100;
  localparam int GEAR_WAIT_NS   = 2 * GEAR_NS;
  localparam int BACK_STALL_NS  = (5 * GEAR_NS) / 2;
  localparam int GEAR_WAIT_CYC  = (GEAR_WAIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int BACK_STALL_CYC = BACK_STALL_NS / CLK_NS;
  localparam int GUARD_CYC      = (2 * MACH_NS + CLK_NS - 1) / CLK_NS;
  localparam int FS_DIV         = 4;

  typedef enum logic [3:0] {
    MODE_WARMUP = 4'b0001,
    MODE_SINGLE = 4'b0010,
    MODE_DUAL   = 4'b0100,
    MODE_LOW    = 4'b1000
  } run_mode_t;

  typedef enum logic [3:0] {
    SW_IDLE   = 4'b0001,
    SW_GEAR   = 4'b0010,
    SW_ALIGN  = 4'b0100,
    SW_STALL  = 4'b1000
  } sw_state_t;

endpackage

/* core/clk_switch_if.sv */
`timescale 1ns/100ps
interface clk_switch_if;
  logic toSlow;
  logic fsRise;
  logic busy;
  logic stall;
  logic selSlow;
  logic done;

  modport ctrl (output toSlow, output fsRise,
                input busy, input stall, input selSlow, input done);
  modport sw   (input toSlow, input fsRise,
                output busy, output stall, output selSlow, output done);
endinterface

/* core/pin_sync_edge.sv */
`timescale 1ns/100ps
module pin_sync_edge
  import clk_mode_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [5:0] pinIn,
  output logic      [5:0] level,
  output logic      [5:0] rise,
  output logic      [5:0] fall
);

  logic [5:0] meta_q;
  logic [5:0] sync_q;
  logic [5:0] last_q;

  // ==========================================================
  // two-stage synchroniser, edges taken after second stage
  genvar i;
  generate
    for (i = 0; i < 6; i++)
    begin : g_bit
      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          meta_q[i] <= 1'b0;
          sync_q[i] <= 1'b0;
          last_q[i] <= 1'b0;
        end
        else
        begin
          meta_q[i] <= pinIn[i];
          sync_q[i] <= meta_q[i];
          last_q[i] <= sync_q[i];
        end
      end
      assign level[i] = sync_q[i];
      assign rise[i]  = sync_q[i] & ~last_q[i];
      assign fall[i]  = ~sync_q[i] & last_q[i];
    end
  endgenerate

endmodule

/* core/main_clk_switch.sv */
`timescale 1ns/100ps
module main_clk_switch
  import clk_mode_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   srst,
  clk_switch_if.sw    sw
);

  sw_state_t  state_q;
  logic [1:0] fsDiv_q;
  logic [2:0] cnt_q;
  logic       sel_q;
  logic       fs4Tick;

  assign fs4Tick = sw.fsRise && (fsDiv_q == 2'(FS_DIV - 1));

  // ==========================================================
  // low clock divided by four
  always_ff @(posedge clk)
  begin
    if (srst)
      fsDiv_q <= 2'h0;
    else if (sw.fsRise)
      fsDiv_q <= fsDiv_q + 2'h1;
  end

  // ==========================================================
  // switch sequence
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_q <= SW_IDLE;
      cnt_q   <= 3'h0;
      sel_q   <= 1'b0;
    end
    else
    begin
      case (state_q)
        SW_IDLE:
          if (sw.toSlow != sel_q)
          begin
            state_q <= sw.toSlow ? SW_GEAR : SW_ALIGN;
            cnt_q   <= 3'h0;
          end
        SW_GEAR:
          if (cnt_q == 3'(GEAR_WAIT_CYC - 1))
            state_q <= SW_ALIGN;
          else
            cnt_q <= cnt_q + 3'h1;
        SW_ALIGN:
          if (fs4Tick)
          begin
            if (sel_q)
            begin
              state_q <= SW_STALL; // RL15
              cnt_q   <= 3'h0;
            end
            else
            begin
              sel_q   <= 1'b1; // RL7
              state_q <= SW_IDLE;
            end
          end
        SW_STALL:
          if (cnt_q == 3'(BACK_STALL_CYC - 1))
          begin
            sel_q   <= 1'b0; // RL14
            state_q <= SW_IDLE;
          end
          else
            cnt_q <= cnt_q + 3'h1;
        default:
          state_q <= SW_IDLE;
      endcase
    end
  end

  // stall main clock while aligning to fs/4 on the switch to slow
  assign sw.stall   = (state_q == SW_STALL) ||
                      (state_q == SW_ALIGN && !sel_q); // RL8
  assign sw.busy    = (state_q != SW_IDLE);
  assign sw.selSlow = sel_q;
  assign sw.done    = (state_q == SW_ALIGN && fs4Tick && !sel_q) ||
                      (state_q == SW_STALL &&
                       cnt_q == 3'(BACK_STALL_CYC - 1));

endmodule

/* dv/idle_slow_ctrl_assertions.sv */
`timescale 1ns/100ps
// ==========================================================
// port checker
module idle_slow_ctrl_assertions
  import clk_mode_pkg::*;
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        extResetPin,
  input wire logic        wdtIrq,
  input wire logic        tbtAck,
  input wire logic        highOscEn,
  input wire logic        warmupStart,
  input wire logic        sysClkReset,
  input wire logic        mainClkSlow,
  input wire logic        mainClkStall,
  input wire logic        haltActive,
  input wire logic        resumeNext,
  input wire logic        tbtService,
  input wire logic        wdtService
);
  // bounds for an fs period of 8 clk cycles
  localparam int FWD_MAX  = 90;
  localparam int BACK_MAX = 70;
  logic sysWr;
  assign sysWr = psel && penable && pwrite && paddr == SYS_CTRL_OFS;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  sequence slowAsk;
    sysWr && pwdata[SLOW_SEL_BIT] && !mainClkSlow;
  endsequence
  sequence fastAsk;
    sysWr && !pwdata[SLOW_SEL_BIT] && mainClkSlow;
  endsequence
  sequence backStall;
    (mainClkSlow && mainClkStall) [*2];
  endsequence

  a_slow_in_time: assert property (disable iff (srst || sysClkReset)
    slowAsk |-> ##[1:FWD_MAX] mainClkSlow) else $error("slow switch late");
  a_fwd_stall: assert property (
    $rose(mainClkSlow) |-> $past(mainClkStall)) else $error("no stall");
  a_back_in_time: assert property (
    disable iff (srst || sysClkReset || extResetPin)
    fastAsk |-> ##[1:BACK_MAX] !mainClkSlow) else $error("back switch late");
  a_back_stall: assert property (
    backStall |=> !mainClkStall) else $error("back stall too long");
  a_halt_release: assert property (
    $fell(haltActive) && !extResetPin |-> resumeNext || tbtService)
    else $error("release without resume");
  a_resume_cause: assert property (
    resumeNext |-> $past(haltActive, 2) && !haltActive)
    else $error("stray resume");
  a_wdt_block: assert property (
    sysWr && pwdata[TG_HALT_BIT] && wdtIrq && !haltActive
    |=> !haltActive && wdtService) else $error("halt taken over wdt");
  a_svc_hold: assert property (
    tbtService && !tbtAck && !extResetPin |=> tbtService)
    else $error("service dropped");
  a_no_rewarm: assert property (
    sysWr && pwdata[HIGH_OSC_BIT] && highOscEn && !extResetPin
    |=> !warmupStart) else $error("warm-up restarted");
  a_ext_warm: assert property (
    $rose(extResetPin) |-> ##[1:5] warmupStart) else $error("no warm-up");
endmodule

bind idle_slow_ctrl idle_slow_ctrl_assertions u_idle_slow_ctrl_assertions (
  .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .extResetPin(extResetPin),
  .wdtIrq(wdtIrq), .tbtAck(tbtAck), .highOscEn(highOscEn),
  .warmupStart(warmupStart), .sysClkReset(sysClkReset),
  .mainClkSlow(mainClkSlow), .mainClkStall(mainClkStall),
  .haltActive(haltActive), .resumeNext(resumeNext),
  .tbtService(tbtService), .wdtService(wdtService)
);

/* dv/idle_slow_ctrl_tb.sv */
`timescale 1ns/100ps
module idle_slow_ctrl_tb
  import clk_mode_pkg::*;
;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr, errSeen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdData;
  logic [3:0]  tbtSrcPin;
  logic [2:0]  lowCnt = 3'h0;
  logic        extResetPin, wdtIrq, tbtAck, highOscStable, lowOscStable;
  logic        highOscEn, warmupStart, sysClkReset, mainClkSlow;
  logic        mainClkStall, haltActive, resumeNext, tbtService;
  logic        wdtService, tbtIrqLatch, lowOscEn, haltSlow;
  int          nFail, samplesChecked, waited;

  idle_slow_ctrl u_idle_slow_ctrl (
    .clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .lowClkPin(lowCnt[2]), .tbtSrcPin, .extResetPin,
    .highOscStable, .lowOscStable, .wdtIrq, .tbtAck, .highOscEn,
    .lowOscEn, .warmupStart, .sysClkReset, .mainClkSlow, .mainClkStall,
    .haltActive, .haltSlow, .resumeNext, .tbtService, .wdtService,
    .tbtIrqLatch
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // low clock, period 8 clk cycles
  always @(posedge clk) lowCnt <= lowCnt + 3'h1;

  // ==========================================================
  // helpers
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      nFail++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic waitFor(ref logic s, input logic v, input int lim);
    waited = 0;
    #1;
    while (s !== v && waited < lim)
    begin
      @(posedge clk);
      #1;
      waited++;
    end
    check(s, v);
    if (s !== v)
      wrapUp();
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      nFail++;
      wrapUp();
    end
    rdData  = prdata;
    errSeen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic doReset();
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
  endtask

  task automatic goSlow();
    wr(SYS_CTRL_OFS, 32'h70);
    waitFor(mainClkSlow, 1'b1, 90);
  endtask

  // ==========================================================
  // scenarios
  task automatic scenRegs();
    rd(SYS_CTRL_OFS);
    check(rdData, SYS_CTRL_RST);
    check(highOscEn, 1'b1);
    rd(12'h010);
    check(errSeen, 1'b1);
  endtask

  task automatic scenPortOff();
    wr(SYS_CTRL_OFS, 32'h40);
    waitFor(sysClkReset, 1'b1, 4);
    rd(STATUS_OFS);
    check(rdData[ST_SCR_BIT], 1'b1);
  endtask

  task automatic scenHalt(input logic irq, input logic [1:0] sel);
    wr(CPU_CTRL_OFS, irq ? 32'h7 : 32'h4);
    wr(TBT_CTRL_OFS, 32'h8 | 32'(sel));
    wr(SYS_CTRL_OFS, 32'h44);
    waitFor(haltActive, 1'b1, 3);
    check(haltSlow, 1'b0);
    @(posedge clk);
    tbtSrcPin <= 4'h1 << sel;
    repeat (5) @(posedge clk);
    tbtSrcPin <= 4'h0;
    #1;
    check(haltActive, 1'b1);
    if (irq)
    begin
      waitFor(tbtService, 1'b1, 8);
      @(posedge clk);
      tbtAck <= 1'b1;
      @(posedge clk);
      tbtAck <= 1'b0;
      waitFor(tbtService, 1'b0, 3);
    end
    else
    begin
      waitFor(resumeNext, 1'b1, 8);
      check(tbtIrqLatch, 1'b1);
    end
    rd(SYS_CTRL_OFS);
    check(rdData[TG_HALT_BIT], 1'b0);
    wr(STATUS_OFS, 32'h20);
  endtask

  task automatic scenWdt();
    @(posedge clk);
    wdtIrq <= 1'b1;
    wr(SYS_CTRL_OFS, 32'h44);
    #1;
    check(wdtService, 1'b1);
    repeat (2) @(posedge clk);
    #1;
    check(haltActive, 1'b0);
    @(posedge clk);
    wdtIrq <= 1'b0;
  endtask

  task automatic scenSlow();
    wr(CPU_CTRL_OFS, 32'h4);
    @(posedge clk);
    lowOscStable <= 1'b1;
    wr(SYS_CTRL_OFS, 32'h60);
    rd(STATUS_OFS);
    check(rdData[3:0], 4'h4);
    goSlow();
    repeat (4) @(posedge clk);
    wr(SYS_CTRL_OFS, 32'h30);
    rd(STATUS_OFS);
    check(rdData[8:0], 9'h088);
  endtask

  task automatic scenBack();
    @(posedge clk);
    highOscStable <= 1'b0;
    wr(SYS_CTRL_OFS, 32'h70);
    waitFor(warmupStart, 1'b1, 4);
    @(posedge clk);
    highOscStable <= 1'b1;
    wr(SYS_CTRL_OFS, 32'h70);
    wr(SYS_CTRL_OFS, 32'h60);
    waitFor(mainClkSlow, 1'b0, 70);
    repeat (4) @(posedge clk);
    wr(SYS_CTRL_OFS, 32'h40);
    rd(STATUS_OFS);
    check(rdData[7:0], 8'h02);
    check(lowOscEn, 1'b0);
  endtask

  task automatic scenExt();
    wr(SYS_CTRL_OFS, 32'h60);
    goSlow();
    @(posedge clk);
    highOscStable <= 1'b0;
    extResetPin   <= 1'b1;
    waitFor(warmupStart, 1'b1, 5);
    @(posedge clk);
    extResetPin <= 1'b0;
    waitFor(mainClkSlow, 1'b0, 100);
    rd(STATUS_OFS);
    check(rdData[3:0], 4'h1);
    @(posedge clk);
    highOscStable <= 1'b1;
    repeat (2) @(posedge clk);
    rd(STATUS_OFS);
    check(rdData[3:0], 4'h2);
  endtask

  task automatic scenEarly();
    wr(CPU_CTRL_OFS, 32'h4);
    wr(SYS_CTRL_OFS, 32'h60);
    wr(SYS_CTRL_OFS, 32'h70);
    wr(SYS_CTRL_OFS, 32'h30);
    waitFor(sysClkReset, 1'b1, 4);
  endtask

  initial
  begin
    srst = 1'b1;
    {psel, penable, pwrite, extResetPin, wdtIrq, tbtAck} = '0;
    {highOscStable, lowOscStable} = 2'b10;
    paddr = '0;
    pwdata = '0;
    tbtSrcPin = '0;
    doReset();
    scenRegs();
    scenPortOff();
    doReset();
    for (int i = 0; i < 4; i++)
      scenHalt(1'b0, i[1:0]);
    scenHalt(1'b1, 2'h1);
    scenWdt();
    doReset();
    scenSlow();
    scenBack();
    scenExt();
    doReset();
    scenEarly();
    wrapUp();
  end
endmodule
